/* File: pmsc_chk.sv */
/*
   Checker of the power mode controller's port behaviour.
   Assumes binding onto power_mode_state_controller, one clock domain.
*/
module pmsc_chk (
   input wire logic       pclk, presetn, pready, pslverr, sleep_entry, deep_sleep_select,
   input wire logic       interrupt_req, wakeup_event, reset_pin_wake, debug_enable,
   input wire logic       stop_ack, regulator_done, cpu_clock_off, stop_request,
   input wire logic       sys_clock_off, regulator_stop,
   input wire logic [2:0] leakage_level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_reset_idle;
      $rose(presetn) |-> !(stop_request | cpu_clock_off | sys_clock_off | regulator_stop);
   endproperty
   property p_wait_gate;
      sleep_entry && !deep_sleep_select && !debug_enable && !interrupt_req && !stop_request
         && !cpu_clock_off |=> cpu_clock_off && !stop_request && !sys_clock_off;
   endproperty
   property p_debug_clock;
      debug_enable && $past(debug_enable) |-> !cpu_clock_off;
   endproperty
   property p_cpu_first;
      $rose(stop_request) |-> cpu_clock_off || debug_enable;
   endproperty
   property p_reg_after_ack;
      $rose(regulator_stop) |-> $past(stop_request) && $past(stop_ack);
   endproperty
   // Interrupt must not pull the regulator back mid-transition
   property p_reg_hold;
      regulator_stop && !sys_clock_off && !regulator_done && !debug_enable |=> regulator_stop;
   endproperty
   property p_leak_level;
      leakage_level != 3'h0 |-> stop_request && (leakage_level == 3'h1 || leakage_level == 3'h3);
   endproperty
   property p_leak_hold;
      (!wakeup_event && !reset_pin_wake)[*4] ##0 (sys_clock_off && leakage_level != 3'h0)
         |=> sys_clock_off;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
   a_wait_gate: assert property (p_wait_gate) else $error("light sleep did not wait");
   a_debug_clock: assert property (p_debug_clock) else $error("core clock off in debug");
   a_cpu_first: assert property (p_cpu_first) else $error("stop request before core gate");
   a_reg_after_ack: assert property (p_reg_after_ack) else $error("regulator before ack");
   a_reg_hold: assert property (p_reg_hold) else $error("regulator entry not held");
   a_leak_level: assert property (p_leak_level) else $error("bad leakage level");
   a_leak_hold: assert property (p_leak_hold) else $error("leakage stop left unwoken");
   c_stopped: cover property ($rose(sys_clock_off));
   c_leak1: cover property (leakage_level == 3'h1 && sys_clock_off);
   c_slverr: cover property (pready && pslverr);
endmodule // pmsc_chk

bind power_mode_state_controller pmsc_chk u_chk (.pclk, .presetn, .pready, .pslverr,
   .sleep_entry, .deep_sleep_select, .interrupt_req, .wakeup_event, .reset_pin_wake,
   .debug_enable, .stop_ack, .regulator_done, .cpu_clock_off, .stop_request,
   .sys_clock_off, .regulator_stop, .leakage_level);

/* File: pmsc_partner.sv */
/*
   Behavioural masters, slaves and regulator facing the controller.
   Assumes the stop handshake outputs of the controller, same clock.
*/
module pmsc_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic stop_request,
   input wire logic regulator_stop,
   output logic     stop_ack,
   output logic     regulator_started,
   output logic     regulator_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] ack_cnt, reg_cnt, lim;
   logic       reg_seen;
   // Slow answers leave a window for aborting the entry
   assign lim = slow ? 4'hC : 4'h2;
   assign stop_ack = stop_request && ack_cnt == lim;
   assign regulator_started = regulator_stop;
   assign regulator_done = reg_cnt == lim;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_cnt <= 4'h0;
         reg_cnt <= 4'h0;
         reg_seen <= 1'b0;
      end else begin
         ack_cnt <= !stop_request ? 4'h0 : (ack_cnt == lim) ? ack_cnt : ack_cnt + 4'h1;
         reg_seen <= regulator_stop;
         reg_cnt <= (regulator_stop != reg_seen) ? 4'h1 :
                    (reg_cnt == 4'h0 || reg_cnt == lim) ? 4'h0 : reg_cnt + 4'h1;
      end
   end
endmodule // pmsc_partner

/* File: pmsc_pkg.sv */
/*
   Constants, register layout and state types of the power mode controller.
   Assumes a 32-bit APB slave, one aligned word per register.
*/
package pmsc_pkg;
   // ----------------------------------------
   // Register indices, byte address is 4x
   // ----------------------------------------
   localparam logic [1:0] IDX_MODE_PROTECTION = 2'h0;
   localparam logic [1:0] IDX_MODE_CONTROL    = 2'h1;
   localparam logic [1:0] IDX_STOP_CONTROL    = 2'h2;
   localparam logic [1:0] IDX_MODE_STATUS     = 2'h3;
   localparam int         ADDR_WIDTH          = 12;
   localparam int         DATA_WIDTH          = 32;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int POS_LOW_POWER_ALLOW    = 5;
   localparam int POS_LOW_LEAKAGE_ALLOW  = 3;
   localparam int POS_LEAKAGE_STOP_ALLOW = 1;
   localparam int POS_RUN_MODE           = 5;
   localparam int POS_STOP_ABORTED       = 3;
   localparam int POS_STOP_MODE          = 0;
   localparam int POS_PARTIAL_STOP       = 6;
   localparam int POS_LEAKAGE_SUBMODE    = 0;

   // ----------------------------------------
   // Field codes
   // ----------------------------------------
   localparam logic [1:0] RUN_MODE_SELECT_RUN       = 2'h0;
   localparam logic [1:0] RUN_MODE_SELECT_LOW_POWER = 2'h2;
   localparam logic [2:0] STOP_MODE_SELECT_NORMAL   = 3'h0;
   localparam logic [2:0] STOP_MODE_SELECT_LOW_PWR  = 3'h2;
   localparam logic [2:0] STOP_MODE_SELECT_LOW_LEAK = 3'h3;
   localparam logic [2:0] STOP_MODE_SELECT_VLL      = 3'h4;
   localparam logic [1:0] PSO_NORMAL     = 2'h0;
   localparam logic [1:0] PSO_BOTH_GATED = 2'h1;
   localparam logic [1:0] PSO_SYS_GATED  = 2'h2;
   localparam logic [1:0] PSO_RESERVED   = 2'h3;
   localparam logic [2:0] LEAKAGE_SUBMODE_SELECT_LEVEL0   = 3'h0;
   localparam logic [2:0] LEAKAGE_SUBMODE_SELECT_LEVEL1   = 3'h1;
   localparam logic [2:0] LEAKAGE_SUBMODE_SELECT_LEVEL3   = 3'h3;

   // ----------------------------------------
   // One-hot mode status codes
   // ----------------------------------------
   localparam logic [6:0] STAT_RUN            = 7'h01;
   localparam logic [6:0] STAT_STOP           = 7'h02;
   localparam logic [6:0] STAT_LOW_POWER_RUN  = 7'h04;
   localparam logic [6:0] STAT_LOW_POWER_WAIT = 7'h08;
   localparam logic [6:0] STAT_LOW_POWER_STOP = 7'h10;
   localparam logic [6:0] STAT_LOW_LEAKAGE    = 7'h20;
   localparam logic [6:0] STAT_VERY_LOW_LEAK  = 7'h40;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [1:0] RST_RUN_MODE  = 2'h0;
   localparam logic [2:0] RST_STOP_MODE = 3'h0;
   localparam logic [1:0] RST_PSO       = 2'h0;
   localparam logic [2:0] RST_LEAKAGE_SUBMODE_SELECT     = 3'h3;

   typedef enum {
      ST_RUN, ST_LOW_POWER_RUN, ST_WAIT, ST_LOW_POWER_WAIT,
      ST_ENTER_REQ, ST_ENTER_REG, ST_STOPPED, ST_EXIT_REG, ST_EXIT_CLK
   } state_t;

   typedef enum {
      SK_STOP, SK_PARTIAL_BOTH, SK_PARTIAL_SYS, SK_LOW_POWER_STOP,
      SK_LOW_LEAKAGE_STOP, SK_VERY_LOW_LEAKAGE_STOP
   } stop_kind_t;
endpackage

/* File: power_mode_state_controller.sv */
/*
   Power mode state machine with its APB register file and the
   entry/exit sequencing towards masters, slaves, clock generator
   and regulator.
   Assumes sleep, interrupt and handshake inputs are synchronous to pclk;
   wakeup-unit events and the reset pin request arrive asynchronously.
*/
// Behaviour
// R1: Any reset returns to normal run.
// R2: Light sleep waits; interrupt returns; reset to run.
// R3: Run deep sleep, codes 00/000 enters stop.
// R4: Partial-stop option 01/10 selects partial stop.
// R5: Low-power run via allow bit and code 10.
// R6: Low-power run deep sleep enters low-power stop.
// R7: Low-power stop from run exits to run.
// R8: From run, low-power stop needs allow bit.
// R9: Leakage-stop allow and 100 enter very-low-leakage.
// R10: Low-leakage allow and 011 enter low-leakage.
// R11: Leakage stops wake only by wakeup-unit/pin.
// R12: Debug keeps core clock running while sleeping.
// R13: Every entry and exit is a sequence; wait and low-power run are entered and left in one step.
// R14: Partial-stop option codes; 11 reserved.
// R15: Mode status one-hot in seven bits.
// R16: Leakage sub-mode codes 000, 001, 011 only.
// R17: Early interrupt aborts stop, sets aborted flag.
// R18: Modes without allow bit are never entered.
// R19: Remember low-power stop origin for exit.
module power_mode_state_controller
(
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [pmsc_pkg::ADDR_WIDTH-1:0]  paddr,
   input  wire logic [pmsc_pkg::DATA_WIDTH-1:0]  pwdata,
   output logic      [pmsc_pkg::DATA_WIDTH-1:0]  prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic                             sleep_entry,
   input  wire logic                             deep_sleep_select,
   input  wire logic                             interrupt_req,
   input  wire logic                             wakeup_event,
   input  wire logic                             reset_pin_wake,
   input  wire logic                             debug_enable,
   input  wire logic                             stop_ack,
   input  wire logic                             regulator_started,
   input  wire logic                             regulator_done,
   output logic                                  cpu_clock_off,
   output logic                                  stop_request,
   output logic                                  sys_clock_off,
   output logic                                  bus_clock_off,
   output logic                                  clock_gen_off,
   output logic                                  regulator_stop,
   output logic                                  low_power_regulation,
   output logic      [2:0]                       leakage_level
);
   import pmsc_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      state_t      state;
      stop_kind_t  target;
      logic        from_lp;
      logic        low_power_allow;
      logic        leakage_stop_allow;
      logic        low_leakage_allow;
      logic [1:0]  run_mode_select;
      logic [2:0]  stop_mode_select;
      logic        stop_aborted_flag;
      logic [1:0]  partial_stop_option;
      logic [2:0]  leakage_submode_select;
      logic [6:0]  mode_status;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [2:0]  wake_sync;
      logic        wake_level;
      logic [2:0]  pin_sync;
      logic        pin_level;
      logic        cpu_clock_off;
      logic        stop_request;
      logic        sys_clock_off;
      logic        bus_clock_off;
      logic        clock_gen_off;
      logic        regulator_stop;
      logic        low_power_regulation;
      logic [2:0]  leakage_level;
   } ctrl_t;

   ctrl_t r;
   ctrl_t next_r;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Status seen for a given state; stop and low-power stop stay hidden
   // under debug or partial stop so software never reads a half mode.
   function automatic logic [6:0] status_of(input state_t st, input stop_kind_t tk,
                                            input logic lp, input logic dbg);
      logic [6:0] s;
      s = lp ? STAT_LOW_POWER_RUN : STAT_RUN;
      case (st)
         ST_RUN:            s = STAT_RUN;
         ST_LOW_POWER_RUN:  s = STAT_LOW_POWER_RUN;
         ST_WAIT:           s = STAT_RUN;
         ST_LOW_POWER_WAIT: s = STAT_LOW_POWER_WAIT;
         ST_STOPPED: begin
            case (tk)
               SK_STOP:                  s = dbg ? STAT_RUN : STAT_STOP;
               SK_LOW_POWER_STOP:        s = dbg ? s : STAT_LOW_POWER_STOP;
               SK_LOW_LEAKAGE_STOP:      s = STAT_LOW_LEAKAGE;
               SK_VERY_LOW_LEAKAGE_STOP: s = STAT_VERY_LOW_LEAK;
               default:                  s = STAT_RUN;
            endcase
         end
         default:           s = s;
      endcase
      return s; // R15
   endfunction

   function automatic logic is_partial(input stop_kind_t tk);
      return (tk == SK_PARTIAL_BOTH) || (tk == SK_PARTIAL_SYS);
   endfunction

   function automatic logic is_leakage(input stop_kind_t tk);
      return (tk == SK_LOW_LEAKAGE_STOP) || (tk == SK_VERY_LOW_LEAKAGE_STOP);
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic       access;
      logic       wr;
      logic [1:0] idx;
      logic       mapped;
      logic       deep_ok;
      stop_kind_t kind;
      logic       exit_now;
      logic       in_stop_seq;
      access      = 1'b0;
      wr          = 1'b0;
      idx         = 2'h0;
      mapped      = 1'b0;
      deep_ok     = 1'b0;
      kind        = SK_STOP;
      exit_now    = 1'b0;
      in_stop_seq = 1'b0;
      next_r      = r;

      // Asynchronous wake sources: level counts once stages two and three agree
      next_r.wake_sync = {r.wake_sync[1:0], wakeup_event};
      if (r.wake_sync[1] == r.wake_sync[2]) begin
         next_r.wake_level = r.wake_sync[2];
      end
      next_r.pin_sync = {r.pin_sync[1:0], reset_pin_wake};
      if (r.pin_sync[1] == r.pin_sync[2]) begin
         next_r.pin_level = r.pin_sync[2];
      end

      // APB: one wait state so every answer comes from a flop
      access         = psel && penable && !r.pready;
      wr             = psel && penable && r.pready && pwrite;
      idx            = paddr[3:2];
      mapped         = (paddr[ADDR_WIDTH-1:4] == '0) && (paddr[1:0] == 2'h0);
      next_r.pready  = access;
      next_r.pslverr = access && !mapped;
      next_r.prdata  = '0;
      if (access && mapped && !pwrite) begin
         if (idx == IDX_MODE_PROTECTION) begin
            next_r.prdata[POS_LOW_POWER_ALLOW]    = r.low_power_allow;
            next_r.prdata[POS_LOW_LEAKAGE_ALLOW]  = r.low_leakage_allow;
            next_r.prdata[POS_LEAKAGE_STOP_ALLOW] = r.leakage_stop_allow;
         end else if (idx == IDX_MODE_CONTROL) begin
            next_r.prdata[POS_RUN_MODE +: 2]  = r.run_mode_select;
            next_r.prdata[POS_STOP_ABORTED]   = r.stop_aborted_flag;
            next_r.prdata[POS_STOP_MODE +: 3] = r.stop_mode_select;
         end else if (idx == IDX_STOP_CONTROL) begin
            next_r.prdata[POS_PARTIAL_STOP +: 2]    = r.partial_stop_option;
            next_r.prdata[POS_LEAKAGE_SUBMODE +: 3] = r.leakage_submode_select;
         end else begin
            next_r.prdata[6:0] = r.mode_status;
         end
      end
      if (wr && mapped) begin
         if (idx == IDX_MODE_PROTECTION) begin
            next_r.low_power_allow    = pwdata[POS_LOW_POWER_ALLOW];
            next_r.low_leakage_allow  = pwdata[POS_LOW_LEAKAGE_ALLOW];
            next_r.leakage_stop_allow = pwdata[POS_LEAKAGE_STOP_ALLOW];
         end else if (idx == IDX_MODE_CONTROL) begin
            next_r.run_mode_select  = pwdata[POS_RUN_MODE +: 2];
            next_r.stop_mode_select = pwdata[POS_STOP_MODE +: 3];
            if (pwdata[POS_STOP_ABORTED]) begin
               next_r.stop_aborted_flag = 1'b0;
            end
         end else if (idx == IDX_STOP_CONTROL) begin
            // Reserved codes are dropped, the field keeps its old value
            if (pwdata[POS_PARTIAL_STOP +: 2] != PSO_RESERVED) begin
               next_r.partial_stop_option = pwdata[POS_PARTIAL_STOP +: 2]; // R14
            end
            if (pwdata[POS_LEAKAGE_SUBMODE +: 3] == LEAKAGE_SUBMODE_SELECT_LEVEL0
                || pwdata[POS_LEAKAGE_SUBMODE +: 3] == LEAKAGE_SUBMODE_SELECT_LEVEL1
                || pwdata[POS_LEAKAGE_SUBMODE +: 3] == LEAKAGE_SUBMODE_SELECT_LEVEL3) begin
               next_r.leakage_submode_select = pwdata[POS_LEAKAGE_SUBMODE +: 3]; // R16
            end
         end
      end

      // Target of a deep sleep from the current run mode
      if (r.stop_mode_select == STOP_MODE_SELECT_NORMAL) begin
         deep_ok = 1'b1;
         if (r.partial_stop_option == PSO_BOTH_GATED) begin
            kind = SK_PARTIAL_BOTH; // R4
         end else if (r.partial_stop_option == PSO_SYS_GATED) begin
            kind = SK_PARTIAL_SYS; // R4
         end else if (r.state == ST_LOW_POWER_RUN) begin
            kind = SK_LOW_POWER_STOP; // R6
         end else begin
            kind = SK_STOP; // R3
         end
      end else if (r.stop_mode_select == STOP_MODE_SELECT_LOW_PWR) begin
         deep_ok = r.low_power_allow; // R8 R18
         kind    = SK_LOW_POWER_STOP; // R6
      end else if (r.stop_mode_select == STOP_MODE_SELECT_LOW_LEAK) begin
         deep_ok = r.low_leakage_allow; // R10 R18
         kind    = SK_LOW_LEAKAGE_STOP;
      end else if (r.stop_mode_select == STOP_MODE_SELECT_VLL) begin
         deep_ok = r.leakage_stop_allow; // R9 R18
         kind    = SK_VERY_LOW_LEAKAGE_STOP;
      end

      // Wake condition of the stop being held
      if (is_leakage(r.target)) begin
         exit_now = r.wake_level || r.pin_level; // R11
      end else begin
         exit_now = interrupt_req;
      end

      case (r.state)
         ST_RUN: begin
            if (sleep_entry && !deep_sleep_select) begin
               next_r.state = ST_WAIT; // R2
            end else if (sleep_entry && deep_ok) begin
               next_r.state   = ST_ENTER_REQ; // R13
               next_r.target  = kind;
               next_r.from_lp = 1'b0; // R19
            end else if (r.low_power_allow && r.run_mode_select == RUN_MODE_SELECT_LOW_POWER) begin
               next_r.state = ST_LOW_POWER_RUN; // R5
            end
         end
         ST_LOW_POWER_RUN: begin
            if (sleep_entry && !deep_sleep_select) begin
               next_r.state = ST_LOW_POWER_WAIT; // R2
            end else if (sleep_entry && deep_ok) begin
               next_r.state   = ST_ENTER_REQ; // R13
               next_r.target  = kind;
               next_r.from_lp = 1'b1; // R19
            end else if (r.run_mode_select == RUN_MODE_SELECT_RUN) begin
               next_r.state = ST_RUN; // R5
            end
         end
         ST_WAIT: begin
            if (interrupt_req) begin
               next_r.state = ST_RUN; // R2
            end
         end
         ST_LOW_POWER_WAIT: begin
            if (interrupt_req) begin
               next_r.state = ST_LOW_POWER_RUN; // R2
            end
         end
         ST_ENTER_REQ: begin
            // Abort window closes once the regulator starts moving
            if (interrupt_req && !regulator_started) begin
               next_r.state             = ST_RUN; // R17
               next_r.stop_aborted_flag = 1'b1; // R17
            end else if (stop_ack) begin
               next_r.state = is_partial(r.target) ? ST_STOPPED : ST_ENTER_REG; // R13
            end
         end
         ST_ENTER_REG: begin
            if (regulator_done) begin
               next_r.state = ST_STOPPED; // R13
            end
         end
         ST_STOPPED: begin
            if (exit_now) begin
               next_r.state = is_partial(r.target) ? ST_EXIT_CLK : ST_EXIT_REG; // R13
            end
         end
         ST_EXIT_REG: begin
            if (regulator_done) begin
               next_r.state = ST_EXIT_CLK;
            end
         end
         ST_EXIT_CLK: begin
            if (r.target == SK_LOW_POWER_STOP && r.from_lp) begin
               next_r.state = ST_LOW_POWER_RUN; // R7
            end else begin
               next_r.state = ST_RUN; // R7 R11
            end
         end
         default: next_r.state = ST_RUN;
      endcase

      // Outputs follow the coming state, so each is a plain flop
      in_stop_seq = (next_r.state == ST_ENTER_REQ) || (next_r.state == ST_ENTER_REG)
                    || (next_r.state == ST_STOPPED) || (next_r.state == ST_EXIT_REG);
      next_r.cpu_clock_off = !debug_enable
                             && (in_stop_seq || next_r.state == ST_WAIT
                                 || next_r.state == ST_LOW_POWER_WAIT); // R12
      next_r.stop_request  = in_stop_seq; // R13
      next_r.sys_clock_off = (next_r.state == ST_STOPPED) && !debug_enable; // R12
      next_r.bus_clock_off = (next_r.state == ST_STOPPED) && !debug_enable
                             && (next_r.target != SK_PARTIAL_SYS); // R14
      next_r.clock_gen_off = ((next_r.state == ST_ENTER_REG) || (next_r.state == ST_STOPPED))
                             && !is_partial(next_r.target); // R13
      next_r.regulator_stop = ((next_r.state == ST_ENTER_REG)
                               || (next_r.state == ST_STOPPED))
                              && !is_partial(next_r.target);
      next_r.low_power_regulation = (next_r.state == ST_LOW_POWER_RUN)
                                    || (next_r.state == ST_LOW_POWER_WAIT)
                                    || next_r.regulator_stop;
      next_r.leakage_level = (in_stop_seq && next_r.target == SK_VERY_LOW_LEAKAGE_STOP)
                             ? r.leakage_submode_select : 3'h0; // R9
      next_r.mode_status = status_of(next_r.state, next_r.target, next_r.from_lp,
                                     debug_enable);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r                        <= '0;
         r.state                  <= ST_RUN; // R1
         r.target                 <= SK_STOP;
         r.run_mode_select        <= RST_RUN_MODE;
         r.stop_mode_select       <= RST_STOP_MODE;
         r.partial_stop_option    <= RST_PSO;
         r.leakage_submode_select <= RST_LEAKAGE_SUBMODE_SELECT;
         r.mode_status            <= STAT_RUN; // R1
      end else begin
         r <= next_r;
      end
   end

   assign prdata               = r.prdata;
   assign pready               = r.pready;
   assign pslverr              = r.pslverr;
   assign cpu_clock_off        = r.cpu_clock_off;
   assign stop_request         = r.stop_request;
   assign sys_clock_off        = r.sys_clock_off;
   assign bus_clock_off        = r.bus_clock_off;
   assign clock_gen_off        = r.clock_gen_off;
   assign regulator_stop       = r.regulator_stop;
   assign low_power_regulation = r.low_power_regulation;
   assign leakage_level        = r.leakage_level;
endmodule // power_mode_state_controller

/* File: test_power_mode_state_controller.sv */
/*
   Self-checking bench of the power mode controller over APB.
   Assumes pmsc_partner answers the stop handshakes.
*/
module test_power_mode_state_controller import pmsc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        sleep_entry, deep_sleep_select, interrupt_req, wakeup_event, reset_pin_wake;
   logic        debug_enable, stop_ack, regulator_started, regulator_done, cpu_clock_off;
   logic        stop_request, sys_clock_off, bus_clock_off, clock_gen_off, regulator_stop;
   logic        low_power_regulation;
   logic [2:0]  leakage_level;
   int          failures, total_checks;
   power_mode_state_controller DUT (.*);
   pmsc_partner u_far (.*);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task report_and_stop;
      if (failures == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         report_and_stop;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_st(input logic [6:0] exp);
      int n;
      n = 0;
      do begin
         apb(1'b0, 12'h00C, 32'h0);
         n++;
      end while (rd[6:0] !== exp && n < 40);
      check(rd, {25'h0, exp});
   endtask
   task sleep(input logic d);
      @(posedge pclk);
      sleep_entry <= 1'b1;
      deep_sleep_select <= d;
      @(posedge pclk);
      sleep_entry <= 1'b0;
   endtask
   task wake(input logic [6:0] to);
      interrupt_req <= 1'b1;
      wait_st(to);
      interrupt_req <= 1'b0;
   endtask
   task wait_clk(input logic lvl);
      int n;
      n = 0;
      while (sys_clock_off !== lvl && n < 50) begin
         @(posedge pclk);
         n++;
      end
      check(32'(sys_clock_off), 32'(lvl));
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      report_and_stop;
   end
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, sleep_entry, deep_sleep_select, interrupt_req} = 6'h0;
      {wakeup_event, reset_pin_wake, debug_enable, slow, presetn} = 5'h0;
      {paddr, pwdata, failures, total_checks} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0); check(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0); check(rd, 32'h3);
      apb(1'b1, 12'h00C, 32'h40); wait_st(STAT_RUN);
      apb(1'b0, 12'h010, 32'h0); check({rd[30:0], err}, 32'h1);
      sleep(1'b0); @(posedge pclk); check(32'(cpu_clock_off), 32'h1);
      wake(STAT_RUN); check(32'(cpu_clock_off), 32'h0);
      sleep(1'b1); wait_st(STAT_STOP); check({bus_clock_off, clock_gen_off}, 32'h3);
      wake(STAT_RUN);
      for (int p = 1; p < 3; p++) begin
         apb(1'b1, 12'h008, 32'(p) << 6);
         sleep(1'b1); wait_clk(1'b1);
         check({bus_clock_off, regulator_stop}, 32'(p == 1) << 1);
         interrupt_req <= 1'b1; wait_clk(1'b0); interrupt_req <= 1'b0;
      end
      apb(1'b1, 12'h008, 32'hC0); apb(1'b0, 12'h008, 32'h0); check(rd, 32'h80);
      apb(1'b1, 12'h008, 32'h01);
      apb(1'b1, 12'h004, 32'h40); apb(1'b0, 12'h00C, 32'h0); check(rd, 32'h1);
      apb(1'b1, 12'h000, 32'h2A); apb(1'b1, 12'h004, 32'h40);
      wait_st(STAT_LOW_POWER_RUN);
      sleep(1'b0); wait_st(STAT_LOW_POWER_WAIT); wake(STAT_LOW_POWER_RUN);
      for (int s = 0; s < 3; s += 2) begin
         apb(1'b1, 12'h004, 32'h40 | 32'(s));
         sleep(1'b1); wait_st(STAT_LOW_POWER_STOP); wake(STAT_LOW_POWER_RUN);
      end
      apb(1'b1, 12'h004, 32'h0); wait_st(STAT_RUN);
      apb(1'b1, 12'h004, 32'h2); sleep(1'b1); wait_st(STAT_LOW_POWER_STOP);
      wake(STAT_RUN);
      apb(1'b1, 12'h004, 32'h3); sleep(1'b1); wait_st(STAT_LOW_LEAKAGE);
      interrupt_req <= 1'b1; apb(1'b0, 12'h00C, 32'h0); apb(1'b0, 12'h00C, 32'h0);
      check(rd, 32'h20);
      interrupt_req <= 1'b0; wakeup_event <= 1'b1; wait_st(STAT_RUN); wakeup_event <= 1'b0;
      apb(1'b1, 12'h004, 32'h4); sleep(1'b1); wait_st(STAT_VERY_LOW_LEAK);
      check(32'(leakage_level), 32'h1);
      reset_pin_wake <= 1'b1; wait_st(STAT_RUN); reset_pin_wake <= 1'b0;
      apb(1'b1, 12'h004, 32'h0); slow <= 1'b1; sleep(1'b1); interrupt_req <= 1'b1;
      apb(1'b0, 12'h004, 32'h0); apb(1'b0, 12'h004, 32'h0); interrupt_req <= 1'b0;
      check({rd[30:0], stop_request}, 32'h10);
      apb(1'b1, 12'h004, 32'h8); apb(1'b0, 12'h004, 32'h0); check(rd, 32'h0);
      slow <= 1'b0; debug_enable <= 1'b1; sleep(1'b1); apb(1'b0, 12'h00C, 32'h0);
      check(32'(cpu_clock_off), 32'h0);
      presetn <= 1'b0; @(posedge pclk); @(posedge pclk);
      presetn <= 1'b1; debug_enable <= 1'b0;
      wait_st(STAT_RUN); check(32'(stop_request), 32'h0);
      report_and_stop;
   end
endmodule // test_power_mode_state_controller
